/* rtl/adc_seq_pkg.sv */
// shared constants for the converter sequencing control block
package adc_seq_pkg;
    // register byte offsets
    localparam logic [11:0] csr_offset = 12'h000;
    localparam logic [11:0] result_offset = 12'h004;
    localparam logic [11:0] int_status_offset = 12'h008;
    localparam logic [11:0] int_mask_offset = 12'h00c;
    // control/status field positions
    localparam int power_bit = 5;
    localparam int complete_bit = 7;
    localparam int chan_lsb = 0;
    localparam int chan_msb = 2;
    // reset values
    localparam logic [7:0] csr_reset = 8'h00;
    localparam logic [7:0] result_reset = 8'h00;
    localparam logic [6:0] count_reset = 7'h00;
    // timing: one conversion lasts this many core clocks
    localparam int conv_cycles = 64;
    localparam logic [6:0] conv_last = 7'(conv_cycles - 1);
    // number of analog inputs on the larger variant
    localparam int num_inputs = 8;
    // interrupt status bit position
    localparam int irq_done_bit = 0;
endpackage

/* rtl/adc_sequencing_control.sv */
// converter sequencing control with apb register access
//
// Overview of operation
// - bit 5 is converter power switch
// - bits 2..0 select analog input channel
// - selector addresses up to eight inputs
// - control write aborts conversion, restarts it when bit 5 is written 1
// - finished conversion loads result, sets bit 7
// - conversions repeat back to back automatically
// - result read returns latest completed value
// - control write clears completion flag
// - each conversion takes 64 core clocks
// - results are 8-bit unsigned, 0 to 255
`timescale 1ns/1ns
`default_nettype none
module adc_sequencing_control
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter analog front end (digitised sample per input)
    input wire logic [7:0] analog_sample [adc_seq_pkg::num_inputs],
    output logic [2:0] channel_select,
    output logic converter_power_on,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_conv = 2'b10
    } conv_state_e;

    conv_state_e state_r;
    logic [7:0] csr_r;
    logic [7:0] result_r;
    logic [6:0] count_r;
    logic [7:0] sample_sync1_r [adc_seq_pkg::num_inputs];
    logic [7:0] sample_sync2_r [adc_seq_pkg::num_inputs];
    logic int_status_r;
    logic int_mask_r;
    logic access;
    logic wr_csr;
    logic wr_status;
    logic wr_mask;
    logic conv_done;
    logic power;

    // apb decode: zero wait state, one access cycle
    assign access = psel && penable;
    assign pready = 1'b1;
    assign wr_csr = access && pwrite && (paddr == adc_seq_pkg::csr_offset) && pstrb[0];
    assign wr_status = access && pwrite && (paddr == adc_seq_pkg::int_status_offset)
        && pstrb[0];
    assign wr_mask = access && pwrite && (paddr == adc_seq_pkg::int_mask_offset) && pstrb[0];
    assign power = csr_r[adc_seq_pkg::power_bit];
    assign converter_power_on = power;
    assign channel_select = csr_r[adc_seq_pkg::chan_msb:adc_seq_pkg::chan_lsb];
    assign conv_done = (state_r == st_conv) && (count_r == adc_seq_pkg::conv_last);

    // unmapped addresses answer with an error, data zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            adc_seq_pkg::csr_offset: prdata = {24'h00_0000, csr_r};
            adc_seq_pkg::result_offset: prdata = {24'h00_0000, result_r};
            adc_seq_pkg::int_status_offset: prdata = {31'h0000_0000, int_status_r};
            adc_seq_pkg::int_mask_offset: prdata = {31'h0000_0000, int_mask_r};
            default: pslverr = access;
        endcase
    end

    // analog pins come from outside the clock domain: two flops each
    genvar gi;
    generate
        for (gi = 0; gi < adc_seq_pkg::num_inputs; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sample_sync1_r[gi] <= 8'h00;
                    sample_sync2_r[gi] <= 8'h00;
                end
                else
                begin
                    sample_sync1_r[gi] <= analog_sample[gi];
                    sample_sync2_r[gi] <= sample_sync1_r[gi];
                end
            end
        end
    endgenerate

    // conversion sequencer; a control write always restarts the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= st_idle;
            count_r <= adc_seq_pkg::count_reset;
        end
        else if (wr_csr)
        begin
            state_r <= pwdata[adc_seq_pkg::power_bit] ? st_conv : st_idle;
            count_r <= adc_seq_pkg::count_reset;
        end
        else
        begin
            case (state_r)
                st_idle:
                begin
                    count_r <= adc_seq_pkg::count_reset;
                end
                st_conv:
                begin
                    // wraps to zero and keeps going after each result
                    count_r <= count_r + 7'h01;
                    if (count_r == adc_seq_pkg::conv_last)
                        count_r <= adc_seq_pkg::count_reset;
                end
                default:
                begin
                    state_r <= st_idle;
                    count_r <= adc_seq_pkg::count_reset;
                end
            endcase
        end
    end

    // control/status: write replaces settings and clears the flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            csr_r <= adc_seq_pkg::csr_reset;
        else if (wr_csr)
        begin
            csr_r <= {1'b0, 1'b0, pwdata[5:0]};
            csr_r[4:3] <= 2'b00;
        end
        else if (conv_done)
            csr_r[adc_seq_pkg::complete_bit] <= 1'b1;
    end

    // result: sampled at the end of the conversion, 0..255 unsigned
    // writes to this offset fall through and are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_r <= adc_seq_pkg::result_reset;
        else if (conv_done && !wr_csr)
            result_r <= sample_sync2_r[channel_select];
    end

    // sticky completion interrupt; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_status_r <= 1'b0;
        else if (conv_done && !wr_csr)
            int_status_r <= 1'b1;
        else if (wr_status && pwdata[adc_seq_pkg::irq_done_bit])
            int_status_r <= 1'b0;
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mask_r <= 1'b0;
        else if (wr_mask)
            int_mask_r <= pwdata[adc_seq_pkg::irq_done_bit];
    end

    assign irq = int_status_r && int_mask_r;
endmodule
`default_nettype wire

/* sim/adc_seq_assertions.sv */
// port checker for the converter sequencing control
`timescale 1ns/1ns
`default_nettype none
module adc_seq_assertions
(
    // watched ports
    input wire logic pclk, presetn, psel, penable, pwrite, converter_power_on,
    input wire logic pslverr, irq,
    input wire logic [3:0] pstrb,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] analog_sample [adc_seq_pkg::num_inputs],
    input wire logic [2:0] channel_select
);
    wire rd = psel && penable && !pwrite;
    logic [15:0] n_r;
    // cycles since a control write; a conversion ends every 64
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) n_r <= 16'h0;
        else if (psel && penable && pwrite && paddr == 12'h0 && pstrb[0]) n_r <= 16'h0;
        else if (n_r != 16'hffff) n_r <= n_r + 16'h1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr == 12'h0 || paddr == 12'h4 || paddr == 12'h8 || paddr == 12'hc;
    // one accepted control write
    sequence csr_wr;
        psel && penable && pwrite && paddr == 12'h0 && pstrb[0];
    endsequence
    AST_CHAN: assert property (csr_wr |=> channel_select == $past(pwdata[2:0])
        && converter_power_on == $past(pwdata[5])) else $error("settings not taken");
    AST_ERR: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped without error");
    AST_OKAY: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped with error");
    AST_IRQ: assert property (rd && paddr == 12'h8 && !prdata[0] |-> !irq)
        else $error("irq without status");
    AST_CLR: assert property (rd && paddr == 12'h0 && n_r < 16'h40 |-> !prdata[7])
        else $error("flag early");
    AST_SET: assert property (rd && paddr == 12'h0 && n_r > 16'h3f
        |-> prdata[7] == converter_power_on) else $error("flag state");
    AST_RES: assert property (rd && paddr == 12'h4 && converter_power_on && n_r > 16'h3f
        |-> prdata[7:0] == analog_sample[channel_select]) else $error("result");
endmodule
bind adc_sequencing_control adc_seq_assertions chk (.*);
`default_nettype wire

/* sim/analog_pins.sv */
// analog pin model, one level per input
`timescale 1ns/1ns
`default_nettype none
module analog_pins
(
    // seed in, levels out
    input wire logic [7:0] base,
    output logic [7:0] level [adc_seq_pkg::num_inputs]
);
    // plain high-impedance inputs, full 0..255 span
    always_comb
        for (int i = 0; i < adc_seq_pkg::num_inputs; i++)
            level[i] = base + 8'(i * 29);
endmodule
`default_nettype wire

/* sim/tb_adc_sequencing_control.sv */
// self-checking bench for the converter sequencing control
`timescale 1ns/1ns
`default_nettype none
module tb_adc_sequencing_control;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h1;
    logic [7:0] base = 8'h10, analog_sample [adc_seq_pkg::num_inputs];
    logic [2:0] channel_select;
    logic pready, pslverr, converter_power_on, irq, last_err;
    int fail_count = 0, n_checks = 0;
    always #5 pclk = ~pclk;
    adc_sequencing_control uut (.*);
    analog_pins pins (.base(base), .level(analog_sample));
    // compare and count
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        fail_count += int'(got !== exp);
        if (got !== exp) $display("FAIL %0t got %h exp %h", $time, got, exp);
    endtask
    // apb transfer held until pready; reads compared
    task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        last_err = pslverr;
        if (!w) ck(prdata[7:0], d);
        {psel, penable} <= 2'h0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard, far beyond the run
    initial
    begin
        #90000 fail_count++;
        conclude();
    end
    // power up, walk all channels, then irq and power off
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        xf(1'h1, 12'hc, 8'h1);
        xf(1'h1, 12'h0, 8'h20);
        repeat (3000) @(posedge pclk);
        for (int c = 0; c < 8; c++)
        begin
            base <= base + 8'h31;
            xf(1'h1, 12'h0, 8'(8'h20 + c));
            repeat (58) @(posedge pclk);
            xf(1'h0, 12'h0, 8'(8'h20 + c));
            repeat (4) @(posedge pclk);
            xf(1'h0, 12'h0, 8'(8'ha0 + c));
            xf(1'h0, 12'h4, base + 8'(c * 29));
        end
        xf(1'h1, 12'hc, 8'h0);
        xf(1'h1, 12'h8, 8'h1);
        xf(1'h0, 12'h8, 8'h0);
        xf(1'h1, 12'h4, 8'h55);
        repeat (70) @(posedge pclk);
        xf(1'h0, 12'h8, 8'h1);
        ck({7'h0, irq}, 8'h0);
        xf(1'h1, 12'hc, 8'h1);
        xf(1'h1, 12'h0, 8'h3);
        ck({7'h0, irq}, 8'h1);
        repeat (80) @(posedge pclk);
        xf(1'h0, 12'h4, base + 8'(7 * 29));
        ck({7'h0, last_err}, 8'h0);
        xf(1'h0, 12'h10, 8'h0);
        ck({7'h0, last_err}, 8'h1);
        conclude();
    end
endmodule
`default_nettype wire
